// ---- rtl/event_mask_pkg.sv ----
// Behaviour
// - A 16-bit fieldbus event mask, written only from the fieldbus side and read-only from the host, selects which fieldbus event request bits reach frame event fields.
// - A 32-bit host event mask, written only from the host port and read-only from the fieldbus side, resets to 00ffff0f and routes application events to the host interrupt.
// - Fieldbus event request bits 7 to 4 mirror the pending status of buffer sync channels 3 to 0.
// - Fieldbus event request bit 3 sets on an application-layer status change and clears on a fieldbus read of the application-layer status register.
// - Fieldbus event request bit 2 sets on a data-link status change and clears on a fieldbus read of the data-link status register.
// - Fieldbus event request bit 0 sets on any latch input change and clears once the fieldbus side has read the latch event times.
// - Multi-byte registers place the least significant byte at the lowest address.
// - The application event request register is a 32-bit read-only register at 0220.
`default_nettype none
package event_mask_pkg;

  localparam int ADDR_W = 16;

  // Register byte addresses
  localparam logic [15:0] FB_MASK_OFS = 16'h0200;
  localparam logic [15:0] HOST_MASK_OFS = 16'h0204;
  localparam logic [15:0] FB_REQ_OFS = 16'h0210;
  localparam logic [15:0] APP_REQ_OFS = 16'h0220;
  localparam logic [15:0] AL_STATUS_OFS = 16'h0130;
  localparam logic [15:0] DL_STATUS_OFS = 16'h0110;

  // Register sizes in bytes
  localparam logic [2:0] FB_MASK_BYTES = 3'd2;
  localparam logic [2:0] HOST_MASK_BYTES = 3'd4;
  localparam logic [2:0] FB_REQ_BYTES = 3'd2;
  localparam logic [2:0] APP_REQ_BYTES = 3'd4;
  localparam logic [2:0] STATUS_BYTES = 3'd2;

  // Values after reset
  localparam logic [15:0] FB_MASK_RST = 16'h0000;
  localparam logic [31:0] HOST_MASK_RST = 32'h00ff_ff0f;

  // Field positions in the fieldbus event request
  localparam int REQ_LATCH_BIT = 0;
  localparam int REQ_DL_BIT = 2;
  localparam int REQ_AL_BIT = 3;
  localparam int REQ_SYNC_LSB = 4;

  // Implemented bits of the application event request
  localparam logic [31:0] APP_REQ_USED = 32'h0000_0f7f;

endpackage : event_mask_pkg
`default_nettype wire

// ---- rtl/latch_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module latch_edge_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic any_change
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;
  logic primed_r;

  // Two-stage synchroniser, only the second stage is looked at
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  // History stage; first sample after reset is not a change
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= sync_r;
      primed_r <= 1'b1;
    end
  end

  assign any_change = primed_r && (sync_r != prev_r);
endmodule // latch_edge_sync
`default_nettype wire

// ---- rtl/event_request_mask_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_request_mask_unit (
  input wire logic ref_clk,
  input wire logic arst_n,
  // Fieldbus side byte access
  input wire logic [event_mask_pkg::ADDR_W-1:0] fb_addr,
  input wire logic fb_wr,
  input wire logic fb_rd,
  input wire logic [7:0] fb_wdata,
  output logic [7:0] fb_rdata,
  // Local host port byte access
  input wire logic [event_mask_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Event sources
  input wire logic [3:0] sync_chan_pending,
  input wire logic al_status_change,
  input wire logic dl_status_change,
  input wire logic latch_input_zero,
  input wire logic latch_input_one,
  input wire logic latch_times_read,
  input wire logic [31:0] app_event_request,
  // Results
  output logic [15:0] frame_event_field,
  output logic host_irq
);
  import event_mask_pkg::*;

  logic [15:0] fb_mask_r;
  logic [31:0] host_mask_r;
  logic [3:0] sync_mirror_r;
  logic al_evt_r;
  logic dl_evt_r;
  logic latch_evt_r;
  logic [15:0] fb_req;
  logic [31:0] app_req;
  logic latch_change;
  logic [7:0] fb_rdata_r;
  logic [7:0] host_rdata_r;
  logic [15:0] frame_evt_r;
  logic host_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // True when addr falls inside a register of size bytes at base
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] base,
                               input logic [2:0] size);
    logic [15:0] top;
    top = base + 16'(size);
    hit = (addr >= base) && (addr < top);
  endfunction

  // byte lane order
  // Byte of a word, lowest address holds the least significant byte
  function automatic logic [7:0] lane(input logic [31:0] word, input logic [1:0] sel);
    lane = word[8*sel +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Latch pins

  latch_edge_sync #(
    .WIDTH(2)
  ) u_latch_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in({latch_input_one, latch_input_zero}),
    .any_change(latch_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers

  // fieldbus-only write
  // Fieldbus mask, host writes to it are ignored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_mask_r <= FB_MASK_RST;
    end else if (fb_wr && hit(fb_addr, FB_MASK_OFS, FB_MASK_BYTES)) begin
      fb_mask_r[8*fb_addr[0] +: 8] <= fb_wdata;
    end
  end

  // host-only write
  // Host mask, fieldbus writes to it are ignored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_mask_r <= HOST_MASK_RST;
    end else if (host_wr && hit(host_addr, HOST_MASK_OFS, HOST_MASK_BYTES)) begin
      host_mask_r[8*host_addr[1:0] +: 8] <= host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fieldbus event request

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_mirror_r <= '0;
    end else begin
      sync_mirror_r <= sync_chan_pending;
    end
  end

  // status change flag
  // Set wins over a clearing read in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      al_evt_r <= 1'b0;
    end else if (al_status_change) begin
      al_evt_r <= 1'b1;
    end else if (fb_rd && hit(fb_addr, AL_STATUS_OFS, STATUS_BYTES)) begin
      al_evt_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dl_evt_r <= 1'b0;
    end else if (dl_status_change) begin
      dl_evt_r <= 1'b1;
    end else if (fb_rd && hit(fb_addr, DL_STATUS_OFS, STATUS_BYTES)) begin
      dl_evt_r <= 1'b0;
    end
  end

  // latch change flag
  // Cleared by the latch units once their times have been read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_evt_r <= 1'b0;
    end else if (latch_change) begin
      latch_evt_r <= 1'b1;
    end else if (latch_times_read) begin
      latch_evt_r <= 1'b0;
    end
  end

  // Assemble request; reserved bits read zero
  always_comb begin
    fb_req = '0;
    fb_req[REQ_SYNC_LSB +: 4] = sync_mirror_r;
    fb_req[REQ_AL_BIT] = al_evt_r;
    fb_req[REQ_DL_BIT] = dl_evt_r;
    fb_req[REQ_LATCH_BIT] = latch_evt_r;
  end

  assign app_req = app_event_request & APP_REQ_USED;

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_evt_r <= '0;
      host_irq_r <= 1'b0;
    end else begin
      frame_evt_r <= fb_req & fb_mask_r;
      host_irq_r <= |(app_req & host_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Fieldbus read port, unmapped bytes read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_rdata_r <= '0;
    end else if (fb_rd) begin
      if (hit(fb_addr, FB_MASK_OFS, FB_MASK_BYTES)) begin
        fb_rdata_r <= lane({16'h0000, fb_mask_r}, fb_addr[1:0]);
      end else if (hit(fb_addr, HOST_MASK_OFS, HOST_MASK_BYTES)) begin
        fb_rdata_r <= lane(host_mask_r, fb_addr[1:0]);
      end else if (hit(fb_addr, FB_REQ_OFS, FB_REQ_BYTES)) begin
        fb_rdata_r <= lane({16'h0000, fb_req}, fb_addr[1:0]);
      end else if (hit(fb_addr, APP_REQ_OFS, APP_REQ_BYTES)) begin
        fb_rdata_r <= lane(app_req, fb_addr[1:0]);
      end else begin
        fb_rdata_r <= 8'h00;
      end
    end
  end

  // Host read port, same map
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata_r <= '0;
    end else if (host_rd) begin
      if (hit(host_addr, FB_MASK_OFS, FB_MASK_BYTES)) begin
        host_rdata_r <= lane({16'h0000, fb_mask_r}, host_addr[1:0]);
      end else if (hit(host_addr, HOST_MASK_OFS, HOST_MASK_BYTES)) begin
        host_rdata_r <= lane(host_mask_r, host_addr[1:0]);
      end else if (hit(host_addr, FB_REQ_OFS, FB_REQ_BYTES)) begin
        host_rdata_r <= lane({16'h0000, fb_req}, host_addr[1:0]);
      end else if (hit(host_addr, APP_REQ_OFS, APP_REQ_BYTES)) begin
        host_rdata_r <= lane(app_req, host_addr[1:0]);
      end else begin
        host_rdata_r <= 8'h00;
      end
    end
  end

  assign fb_rdata = fb_rdata_r;
  assign host_rdata = host_rdata_r;
  assign frame_event_field = frame_evt_r;
  assign host_irq = host_irq_r;
endmodule // event_request_mask_unit
`default_nettype wire

// ---- verification/event_request_mask_unit_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_request_mask_unit_checker
  import event_mask_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] fb_addr,
  input wire logic fb_wr,
  input wire logic fb_rd,
  input wire logic [7:0] fb_wdata,
  input wire logic [7:0] fb_rdata,
  input wire logic [3:0] sync_chan_pending,
  input wire logic al_status_change,
  input wire logic dl_status_change,
  input wire logic [31:0] app_event_request,
  input wire logic [15:0] frame_event_field,
  input wire logic host_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] mask_lo_r;
  // Last low mask byte written from the fieldbus side
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_lo_r <= 8'h00;
    end else if (fb_wr && fb_addr == 16'h0200) begin
      mask_lo_r <= fb_wdata;
    end
  end
  // Fieldbus read of the low mask byte
  sequence mask_lo_rd;
    fb_rd && fb_addr == 16'h0200;
  endsequence
  chk_rsvd_high: assert property (frame_event_field[15:8] == 8'h00)
    else $error("frame field high byte set");
  chk_rsvd_one: assert property (!frame_event_field[1])
    else $error("frame field bit one set");
  chk_sync_src: assert property ((frame_event_field[7:4] & ~$past(sync_chan_pending, 2)) == 4'h0)
    else $error("sync bit without pending channel");
  chk_al_cause: assert property ($rose(frame_event_field[3]) |-> $past(al_status_change, 2) || $past(fb_wr, 2))
    else $error("status flag rose without cause");
  chk_dl_cause: assert property ($rose(frame_event_field[2]) |-> $past(dl_status_change, 2) || $past(fb_wr, 2))
    else $error("link flag rose without cause");
  chk_irq_cause: assert property (host_irq |-> (($past(app_event_request) | $past(app_event_request, 2)) & 32'h0f7f) != 0)
    else $error("irq without request");
  chk_unmapped_zero: assert property (fb_rd && fb_addr == 16'h0300 |=> fb_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_back: assert property (mask_lo_rd |=> fb_rdata == $past(mask_lo_r))
    else $error("mask readback wrong");
endmodule // event_request_mask_unit_checker
bind event_request_mask_unit event_request_mask_unit_checker u_chk (.ref_clk(ref_clk),
  .arst_n(arst_n), .fb_addr(fb_addr), .fb_wr(fb_wr), .fb_rd(fb_rd), .fb_wdata(fb_wdata),
  .fb_rdata(fb_rdata), .sync_chan_pending(sync_chan_pending),
  .al_status_change(al_status_change), .dl_status_change(dl_status_change),
  .app_event_request(app_event_request), .frame_event_field(frame_event_field),
  .host_irq(host_irq));
`default_nettype wire

// ---- verification/latch_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module latch_source_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic kick,
  input wire logic kick_one,
  output logic latch_input_zero,
  output logic latch_input_one
);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) latch_input_zero <= 1'b0;
    else if (kick) latch_input_zero <= !latch_input_zero;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) latch_input_one <= 1'b0;
    else if (kick_one) latch_input_one <= !latch_input_one;
  end
endmodule // latch_source_model
`default_nettype wire

// ---- verification/event_request_mask_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_request_mask_unit_tb;
  logic ref_clk, arst_n, fb_wr, fb_rd, host_wr, host_rd, al_c, dl_c, lt_rd, kick, irq;
  logic [15:0] fb_addr, host_addr, frame;
  logic [7:0] fb_wdata, fb_rdata, host_wdata, host_rdata, rd_byte;
  logic [3:0] sync_p;
  logic [31:0] app;
  logic lz, lo, kick_one;
  int n_fail, comparisons, cyc;
  event_request_mask_unit u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .fb_addr(fb_addr),
    .fb_wr(fb_wr), .fb_rd(fb_rd), .fb_wdata(fb_wdata), .fb_rdata(fb_rdata),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .sync_chan_pending(sync_p), .al_status_change(al_c),
    .dl_status_change(dl_c), .latch_input_zero(lz), .latch_input_one(lo),
    .latch_times_read(lt_rd), .app_event_request(app), .frame_event_field(frame),
    .host_irq(irq));
  latch_source_model u_src (.ref_clk(ref_clk), .arst_n(arst_n), .kick(kick),
    .kick_one(kick_one), .latch_input_zero(lz), .latch_input_one(lo));
  // Clock and cycle ceiling
  always #20 ref_clk = !ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run;
    end
  end
  task w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // One byte access on either port, read byte lands in rd_byte
  task acc(input logic h, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    if (h) begin
      host_addr <= a; host_wdata <= d; host_wr <= wr; host_rd <= !wr;
    end else begin
      fb_addr <= a; fb_wdata <= d; fb_wr <= wr; fb_rd <= !wr;
    end
    @(posedge ref_clk);
    {host_wr, host_rd, fb_wr, fb_rd} <= 4'h0;
    w(1);
    rd_byte = h ? host_rdata : fb_rdata;
  endtask
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task s_reset;
    logic [7:0] hm [4];
    hm = '{8'h0f, 8'hff, 8'hff, 8'h00};
    acc(0, 0, 16'h0201, 0); cmp("fb_mask_hi", 0, rd_byte);
    for (int i = 0; i < 4; i++) begin
      acc(0, 0, 16'h0204 + i, 0); cmp("host_mask", hm[i], rd_byte);
    end
    acc(0, 0, 16'h0300, 0); cmp("unmapped", 0, rd_byte);
  endtask
  task s_mask;
    acc(0, 1, 16'h0200, 8'hff); acc(0, 1, 16'h0201, 8'h5a);
    acc(1, 1, 16'h0200, 8'h00); acc(0, 1, 16'h0204, 8'h00);
    acc(0, 0, 16'h0200, 0); cmp("fb_mask_lo", 8'hff, rd_byte);
    acc(1, 0, 16'h0201, 0); cmp("fb_mask_host", 8'h5a, rd_byte);
    acc(1, 0, 16'h0204, 0); cmp("host_mask_fb", 8'h0f, rd_byte);
  endtask
  task s_sync;
    @(posedge ref_clk);
    sync_p <= 4'h9;
    acc(0, 0, 16'h0210, 0); cmp("req_sync", 8'h90, rd_byte);
    cmp("frame_sync", 16'h0090, frame);
    @(posedge ref_clk);
    sync_p <= 4'h0;
  endtask
  task s_status;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk); al_c <= (i == 0); dl_c <= (i == 1);
      @(posedge ref_clk); al_c <= 0; dl_c <= 0;
      w(2); cmp("flag_set", 1, frame[3 - i]);
      acc(1, 0, i ? 16'h0111 : 16'h0130, 0);
      w(2); cmp("flag_host", 1, frame[3 - i]);
      acc(0, 0, i ? 16'h0111 : 16'h0130, 0);
      w(2); cmp("flag_clr", 0, frame[3 - i]);
    end
  endtask
  task s_latch;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk); kick <= (i == 0); kick_one <= (i == 1);
      @(posedge ref_clk); kick <= 0; kick_one <= 0;
      w(7); cmp("latch_set", 1, frame[0]);
      @(posedge ref_clk); lt_rd <= 1;
      @(posedge ref_clk); lt_rd <= 0;
      w(2); cmp("latch_clr", 0, frame[0]);
    end
  endtask
  task s_irq;
    @(posedge ref_clk);
    app <= 32'h0000_1100;
    w(4); cmp("irq_on", 1, irq);
    acc(0, 0, 16'h0221, 0); cmp("app_req", 8'h01, rd_byte);
    acc(1, 1, 16'h0205, 8'hfe);
    w(2); cmp("irq_masked", 0, irq);
  endtask
  task complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {ref_clk, arst_n, fb_wr, fb_rd, host_wr, host_rd, al_c, dl_c, lt_rd, kick, kick_one} = 0;
    {fb_addr, host_addr, fb_wdata, host_wdata, sync_p, app} = 0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1;
    s_reset; s_mask; s_sync; s_status; s_latch; s_irq;
    complete_run;
  end
endmodule // event_request_mask_unit_tb
`default_nettype wire
